// File: logic/rpd_pkg.sv
// Package for the power-defaults, test-or-reset pin and trim-lock block
package rpd_pkg;
  localparam logic [7:0] ADDR_DIGITAL_TRIM = 8'h08;
  localparam logic [7:0] ADDR_ANALOG_TRIM = 8'h12;
  localparam logic [7:0] ADDR_TIMER_CTRL = 8'h11;
  localparam logic [7:0] ADDR_ALARM1_CTRL = 8'h0A;
  localparam logic [7:0] ADDR_ALARM2_CTRL = 8'h14;
  localparam logic [7:0] ADDR_MISC_CTRL = 8'h13;
  localparam int FT_BIT = 6;
  localparam int LOCK_BIT = 6;
  localparam int COUNT_WIDTH = 24;
  localparam int MCLK_HZ = 50000000;
  localparam int TEST_HZ = 512;
  localparam int TEST_HALF_CYCLES = MCLK_HZ / (2 * TEST_HZ);
  localparam int COPY_TIME_MS = 8;
  localparam int COPY_CYCLES = (MCLK_HZ / 1000) * COPY_TIME_MS;
  localparam logic [7:0] DIGITAL_TRIM_INIT = 8'h00;
  localparam logic [7:0] TIMER_CTRL_INIT = 8'h03;
  localparam logic [7:0] TIMER_CTRL_WARM_CLR = 8'h7F;
  localparam logic [7:0] ALARM1_CTRL_INIT = 8'h40;
  localparam logic [7:0] ALARM1_CTRL_WARM_SET = 8'h40;
  localparam logic [7:0] ALARM2_CTRL_INIT = 8'h00;
  localparam logic [7:0] MISC_CTRL_INIT = 8'h81;
  localparam logic [7:0] MISC_CTRL_WARM_CLR = 8'hFF;
  localparam logic [7:0] ANALOG_TRIM_INIT = 8'h00;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rpd_req_t;
endpackage

// File: logic/rpd_counter.sv
// Down counter with terminal pulse, used for the test wave and the copy delay
module rpd_counter #(
  parameter int WIDTH = 24
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic run_i,
  input wire logic [WIDTH-1:0] load_i,
  output logic done_o
);
  logic [WIDTH-1:0] cnt;
  wire at_zero = (cnt == '0);
  assign done_o = run_i && at_zero;
  always_ff @(posedge mclk_i) begin
    if (!nrst_i || !run_i || at_zero) begin
      cnt <= load_i;
    end else begin
      cnt <= cnt - 1'b1;
    end
  end
endmodule

// File: logic/rpd_top.sv
// Test-or-reset pin, power-up control defaults and analog trim lock
// ---------------------------------------------------------------
// What this block does
// - FT one drives 512 Hz on pin
// - FT zero, supply good, out of reset: pin high
// - Supply fail with FT: clear FT, pin low
// - Every power-up starts with FT zero
// - Initial power-up loads full default set
// - Battery power-up: halt set, few bits cleared
// - Untabulated bits may stay undetermined
// - Lock copies factory value, register read-only
// - Unlocked trim register is plain read/write
// - Copy finishes within about 8 ms
// ---------------------------------------------------------------
module rpd_top
  import rpd_pkg::*;
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic battery_backed_i,
  input wire logic vcc_good_i,
  input wire rpd_pkg::rpd_req_t req_i,
  input wire logic [7:0] factory_trim_i,
  output logic [7:0] rdata_o,
  output logic test_or_reset_pin_o,
  output logic test_or_reset_pin_oe_o,
  output logic copy_busy_o
);
  import rpd_pkg::*;

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  // Bit layout: digital trim [6] test enable; timer ctrl [7] enable,
  // [6] pulse mode, [5] irq enable, [1:0] clock select; alarm1 ctrl
  // [4:0] repeat, [6] halt update; alarm2 ctrl [4:0] repeat,
  // [6] event enable, [7] irq enable; misc [7] oscillator fail,
  // [6] trim lock, [3:1] rate upper, [0] rate lsb
  logic [7:0] digital_trim_control;
  logic [7:0] analog_trim_value;
  logic [7:0] timer_ctrl;
  logic [7:0] alarm1_ctrl;
  logic [7:0] alarm2_ctrl;
  logic [7:0] misc_ctrl;
  logic wave;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  wire sel_digital = (req_i.addr == ADDR_DIGITAL_TRIM);
  wire sel_analog = (req_i.addr == ADDR_ANALOG_TRIM);
  wire sel_timer = (req_i.addr == ADDR_TIMER_CTRL);
  wire sel_alarm1 = (req_i.addr == ADDR_ALARM1_CTRL);
  wire sel_alarm2 = (req_i.addr == ADDR_ALARM2_CTRL);
  wire sel_misc = (req_i.addr == ADDR_MISC_CTRL);
  wire wr_digital = req_i.wr && sel_digital;
  wire wr_analog = req_i.wr && sel_analog;
  wire wr_timer = req_i.wr && sel_timer;
  wire wr_alarm1 = req_i.wr && sel_alarm1;
  wire wr_alarm2 = req_i.wr && sel_alarm2;
  wire wr_misc = req_i.wr && sel_misc;
  wire calib_lock = misc_ctrl[LOCK_BIT];
  wire lock_rise = wr_misc && req_i.wdata[LOCK_BIT] && !calib_lock;
  wire ft_on = digital_trim_control[FT_BIT];
  wire [7:0] ft_mask = 8'h01 << FT_BIT;
  wire wave_tick;
  wire copy_done;

  // ---------------------------------------------------------------
  // Power-up defaults
  // ---------------------------------------------------------------
  // Reset stands for a power-up; the battery input picks cold or warm.
  // A warm start keeps the held bits, so its values come from the registers.
  wire cold_start = !battery_backed_i;
  wire [7:0] boot_digital_trim = cold_start ? DIGITAL_TRIM_INIT
    : (digital_trim_control & ~ft_mask);
  wire [7:0] boot_timer_ctrl = cold_start ? TIMER_CTRL_INIT
    : (timer_ctrl & TIMER_CTRL_WARM_CLR);
  wire [7:0] boot_alarm1_ctrl = cold_start ? ALARM1_CTRL_INIT
    : (alarm1_ctrl | ALARM1_CTRL_WARM_SET);
  wire [7:0] boot_alarm2_ctrl = cold_start ? ALARM2_CTRL_INIT : alarm2_ctrl;
  wire [7:0] boot_misc_ctrl = cold_start ? MISC_CTRL_INIT : (misc_ctrl & MISC_CTRL_WARM_CLR);
  wire [7:0] boot_analog_trim = cold_start ? ANALOG_TRIM_INIT : analog_trim_value;
  // Other bits of these registers are simply unspecified after cold power

  // ---------------------------------------------------------------
  // Supply failure and writes
  // ---------------------------------------------------------------
  // A supply failure with FT set beats a write to the same register, so the pin
  // cannot keep showing the test wave while reset is due
  wire ft_supply_clear = !vcc_good_i && ft_on;
  wire [7:0] run_digital_trim = ft_supply_clear ? (digital_trim_control & ~ft_mask)
    : (wr_digital ? req_i.wdata : digital_trim_control);
  wire [7:0] run_timer_ctrl = wr_timer ? req_i.wdata : timer_ctrl;
  wire [7:0] run_alarm1_ctrl = wr_alarm1 ? req_i.wdata : alarm1_ctrl;
  wire [7:0] run_alarm2_ctrl = wr_alarm2 ? req_i.wdata : alarm2_ctrl;
  wire [7:0] run_misc_ctrl = wr_misc ? req_i.wdata : misc_ctrl;
  wire analog_write_ok = wr_analog && !calib_lock;
  wire [7:0] run_analog_trim = copy_done ? factory_trim_i
    : (analog_write_ok ? req_i.wdata : analog_trim_value);

  // ---------------------------------------------------------------
  // Next values
  // ---------------------------------------------------------------
  // Reset picks the power-up value, otherwise the running value
  wire [7:0] next_digital_trim_control = nrst_i ? run_digital_trim : boot_digital_trim;
  wire [7:0] next_timer_ctrl = nrst_i ? run_timer_ctrl : boot_timer_ctrl;
  wire [7:0] next_alarm1_ctrl = nrst_i ? run_alarm1_ctrl : boot_alarm1_ctrl;
  wire [7:0] next_alarm2_ctrl = nrst_i ? run_alarm2_ctrl : boot_alarm2_ctrl;
  wire [7:0] next_misc_ctrl = nrst_i ? run_misc_ctrl : boot_misc_ctrl;
  wire [7:0] next_analog_trim_value = nrst_i ? run_analog_trim : boot_analog_trim;

  // ---------------------------------------------------------------
  // Digital trim and test enable
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    digital_trim_control <= next_digital_trim_control;
  end

  // ---------------------------------------------------------------
  // Timer and alarm controls
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    timer_ctrl <= next_timer_ctrl;
  end

  always_ff @(posedge mclk_i) begin
    alarm1_ctrl <= next_alarm1_ctrl;
  end

  always_ff @(posedge mclk_i) begin
    alarm2_ctrl <= next_alarm2_ctrl;
  end

  // ---------------------------------------------------------------
  // Misc control and trim lock
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    misc_ctrl <= next_misc_ctrl;
  end

  // ---------------------------------------------------------------
  // Analog trim
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    analog_trim_value <= next_analog_trim_value;
  end

  // ---------------------------------------------------------------
  // Factory copy sequence
  // ---------------------------------------------------------------
  // The copy waits the full settle time, so software sees it land late;
  // the lock keeps host writes out meanwhile, unless a misc control write clears it
  typedef enum logic [1:0] {
    COPY_IDLE = 2'b01,
    COPY_WAIT = 2'b10
  } rpd_copy_state_t;
  rpd_copy_state_t copy_state;
  rpd_copy_state_t next_copy_state;
  wire copying = (copy_state == COPY_WAIT);

  always_comb begin
    if (!nrst_i) begin
      next_copy_state = COPY_IDLE;
    end else begin
      next_copy_state = copy_state;
      unique case (copy_state)
        COPY_IDLE: begin
          if (lock_rise) next_copy_state = COPY_WAIT;
        end
        COPY_WAIT: begin
          if (copy_done) next_copy_state = COPY_IDLE;
        end
        default: next_copy_state = COPY_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    copy_state <= next_copy_state;
  end

  rpd_counter #(.WIDTH(COUNT_WIDTH)) copy_timer (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .run_i(copying),
    .load_i(COUNT_WIDTH'(COPY_CYCLES - 1)),
    .done_o(copy_done)
  );

  // ---------------------------------------------------------------
  // Test waveform and pin
  // ---------------------------------------------------------------
  rpd_counter #(.WIDTH(COUNT_WIDTH)) wave_timer (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .run_i(ft_on),
    .load_i(COUNT_WIDTH'(TEST_HALF_CYCLES - 1)),
    .done_o(wave_tick)
  );

  // The wave restarts low each time the test is enabled
  wire next_wave = nrst_i && ft_on && (wave ^ wave_tick);
  always_ff @(posedge mclk_i) begin
    wave <= next_wave;
  end

  // Open drain: driven only for a low level, high comes from the pull-up
  wire pin_level = !vcc_good_i ? 1'b0 : (ft_on ? wave : 1'b1);
  assign test_or_reset_pin_o = 1'b0;
  assign test_or_reset_pin_oe_o = !nrst_i || !pin_level;
  assign copy_busy_o = copying;

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  // Unmapped addresses read as zero
  assign rdata_o = ({8{sel_digital}} & digital_trim_control)
    | ({8{sel_analog}} & analog_trim_value)
    | ({8{sel_timer}} & timer_ctrl)
    | ({8{sel_alarm1}} & alarm1_ctrl)
    | ({8{sel_alarm2}} & alarm2_ctrl)
    | ({8{sel_misc}} & misc_ctrl);
endmodule

// File: tb/rpd_properties.sv
// Port checks for the reset pin, power-up defaults and trim lock
module rpd_properties
  import rpd_pkg::*;
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic battery_backed_i,
  input wire logic vcc_good_i,
  input wire rpd_pkg::rpd_req_t req_i,
  input wire logic [7:0] rdata_o,
  input wire logic test_or_reset_pin_oe_o,
  input wire logic copy_busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  logic [19:0] busy_cnt;
  wire lock_wr = req_i.wr && req_i.addr == ADDR_MISC_CTRL && req_i.wdata[6];
  always_ff @(posedge mclk_i) busy_cnt <= (nrst_i && copy_busy_o) ? busy_cnt + 20'h1 : 20'h0;
  a_fail_pin_low: assert property (!vcc_good_i |-> test_or_reset_pin_oe_o) else $error("pin not low");
  a_ft_cleared: assert property (!vcc_good_i && !req_i.wr ##1 vcc_good_i && req_i.addr == ADDR_DIGITAL_TRIM
    |-> !rdata_o[6]) else $error("test bit kept");
  a_ft_off_high: assert property (req_i.wr && req_i.addr == ADDR_DIGITAL_TRIM && !req_i.wdata[6] ##1 vcc_good_i
    |-> !test_or_reset_pin_oe_o) else $error("pin not released");
  a_boot_ft_zero: assert property ($rose(nrst_i) && req_i.addr == ADDR_DIGITAL_TRIM |-> !rdata_o[6])
    else $error("test bit set at power-up");
  a_cold_misc: assert property ($rose(nrst_i) && !battery_backed_i && req_i.addr == ADDR_MISC_CTRL
    |-> rdata_o == MISC_CTRL_INIT) else $error("cold misc default");
  a_warm_halt: assert property ($rose(nrst_i) && battery_backed_i && req_i.addr == ADDR_ALARM1_CTRL
    |-> rdata_o[6]) else $error("halt not set");
  a_lock_start: assert property ($rose(copy_busy_o) |-> $past(lock_wr)) else $error("copy without lock");
  a_copy_bound: assert property (busy_cnt <= COPY_CYCLES) else $error("copy too long");
  cover property ($rose(copy_busy_o));
  cover property (!vcc_good_i);
  cover property ($rose(nrst_i) && battery_backed_i);
endmodule
bind rpd_top rpd_properties rpd_properties_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .battery_backed_i(battery_backed_i),
  .vcc_good_i(vcc_good_i), .req_i(req_i), .rdata_o(rdata_o), .test_or_reset_pin_oe_o(test_or_reset_pin_oe_o),
  .copy_busy_o(copy_busy_o));

// File: tb/rpd_host_model.sv
// Host side of the shared pin: pull-up and reset input
module rpd_host_model (
  input wire logic pin_oe_i,
  output logic pin_level_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Open drain, so a released pin rises through the pull-up
  assign pin_level_o = pin_oe_i ? 1'b0 : 1'b1;
endmodule

// File: tb/test_rtc_power_defaults_test_reset_pin.sv
// Self-checking bench for the reset pin, power-up defaults and trim lock
module test_rtc_power_defaults_test_reset_pin;
  timeunit 1ns;
  timeprecision 1ns;
  import rpd_pkg::*;
  logic mclk_i = 1'b0, nrst_i = 1'b0, batt = 1'b0, vcc = 1'b1, stb = 1'b0, oe, pin_o, busy, level;
  rpd_req_t req = '0;
  logic [7:0] trim = 8'h00, rdata, v;
  logic [7:0] expq[$];
  int mismatches = 0, n_compared = 0, k;
  always #10 mclk_i = ~mclk_i;
  rpd_top rpd_top_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .battery_backed_i(batt), .vcc_good_i(vcc), .req_i(req),
    .factory_trim_i(trim), .rdata_o(rdata), .test_or_reset_pin_o(pin_o), .test_or_reset_pin_oe_o(oe), .copy_busy_o(busy));
  rpd_host_model rpd_host_model_i (.pin_oe_i(oe), .pin_level_o(level));
  task chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    req <= '{1'b1, a, d};
    @(posedge mclk_i);
    req.wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    req <= '{1'b0, a, 8'h00};
    expq.push_back(e);
    stb <= 1'b1;
    @(posedge mclk_i);
    stb <= 1'b0;
  endtask
  task rst(input logic b, input logic [7:0] a);
    @(posedge mclk_i);
    nrst_i <= 1'b0;
    batt <= b;
    req <= '{1'b0, a, 8'h00};
    repeat (3) @(posedge mclk_i);
    nrst_i <= 1'b1;
  endtask
  // Reads settle before the falling edge
  always @(negedge mclk_i) if (stb === 1'b1) chk("rdata", expq.pop_front(), rdata);
  initial begin
    v = $urandom(32'hAB5F4E37);
    rst(1'b0, ADDR_MISC_CTRL);
    rd(ADDR_TIMER_CTRL, TIMER_CTRL_INIT);
    rd(ADDR_ALARM1_CTRL, ALARM1_CTRL_INIT);
    rd(ADDR_ALARM2_CTRL, ALARM2_CTRL_INIT);
    rd(ADDR_DIGITAL_TRIM, 8'h00);
    chk("pin", 8'h01, {7'h00, level});
    for (k = 0; k < 4; k++) begin
      v = $urandom;
      wr(ADDR_ANALOG_TRIM, v);
      rd(ADDR_ANALOG_TRIM, v);
    end
    wr(ADDR_DIGITAL_TRIM, 8'h40);
    @(negedge mclk_i);
    v = {7'h00, level};
    for (k = 0; k < TEST_HALF_CYCLES + 4 && {7'h00, level} === v; k++) @(negedge mclk_i);
    chk("wave", {7'h00, ~v[0]}, {7'h00, level});
    if (k >= TEST_HALF_CYCLES + 4) close_out;
    @(posedge mclk_i);
    vcc <= 1'b0;
    @(negedge mclk_i);
    chk("pin", 8'h00, {7'h00, level});
    @(posedge mclk_i);
    vcc <= 1'b1;
    rd(ADDR_DIGITAL_TRIM, 8'h00);
    wr(ADDR_DIGITAL_TRIM, 8'h00);
    @(negedge mclk_i);
    chk("pin", 8'h01, {7'h00, level});
    v = $urandom & 8'hDF;
    wr(ADDR_ALARM2_CTRL, v);
    wr(ADDR_TIMER_CTRL, 8'h83);
    wr(ADDR_DIGITAL_TRIM, 8'h40);
    rst(1'b1, ADDR_DIGITAL_TRIM);
    rd(ADDR_DIGITAL_TRIM, 8'h00);
    rd(ADDR_ALARM2_CTRL, v);
    rd(ADDR_TIMER_CTRL, 8'h83 & TIMER_CTRL_WARM_CLR);
    wr(ADDR_ALARM1_CTRL, 8'h00);
    rst(1'b1, ADDR_ALARM1_CTRL);
    rd(ADDR_ALARM1_CTRL, ALARM1_CTRL_WARM_SET);
    trim <= $urandom;
    wr(ADDR_ANALOG_TRIM, 8'h5A);
    wr(ADDR_MISC_CTRL, MISC_CTRL_INIT | 8'h40);
    @(negedge mclk_i);
    chk("busy", 8'h01, {7'h00, busy});
    wr(ADDR_ANALOG_TRIM, 8'hA5);
    rd(ADDR_ANALOG_TRIM, 8'h5A);
    close_out;
  end
endmodule
